//--- core/dual_dac_pkg.sv
// Shared constants and types for the dual converter serial command logic
package dual_dac_pkg;

  // ==========================================================================
  // Word layout
  // ==========================================================================
  localparam int WORD_BITS      = 16;
  localparam int CMD_BITS       = 4;
  localparam int LEVEL_BITS     = 10;
  localparam int CMD_MSB        = 15;
  localparam int CMD_LSB        = 12;
  localparam int LEVEL_MSB      = 11;
  localparam int LEVEL_LSB      = 2;
  localparam int PAD_HIGH_POS   = 1;
  localparam int PAD_LOW_POS    = 0;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_LOAD_A     = 4'h1;
  localparam logic [3:0] CMD_LOAD_B     = 4'h2;
  localparam logic [3:0] CMD_UPDATE     = 4'h8;
  localparam logic [3:0] CMD_LOAD_A_UPD = 4'h9;
  localparam logic [3:0] CMD_LOAD_B_UPD = 4'ha;
  localparam logic [3:0] CMD_WAKE       = 4'hd;
  localparam logic [3:0] CMD_SLEEP      = 4'he;
  localparam logic [3:0] CMD_LOAD_BOTH  = 4'hf;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [9:0]  LEVEL_RESET = 10'h000;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic        SLEEP_RESET = 1'b0;

  typedef logic [9:0] level_t;

  // A completed word as seen in the core domain
  typedef struct packed {
    logic [3:0] command_code;
    level_t     level_code;
  } command_word_s;

  // Both channels of one register bank
  typedef struct packed {
    level_t chan_a;
    level_t chan_b;
  } level_pair_s;

endpackage : dual_dac_pkg

//--- core/serial_word_shifter.sv
// Link-clock shift register and word hand-off toggle
`timescale 1ns/100ps
`default_nettype none

module serial_word_shifter
  import dual_dac_pkg::*;
(
  input  wire logic               shift_clk_in,
  input  wire logic               select_load_strobe_n_in,
  input  wire logic               serial_word_in,
  output var  logic [15:0]        word_out,
  output var  logic               word_toggle_out
);

  // No reset pin reaches this domain; the start values stand in for power-up
  logic [15:0] shift_reg = WORD_RESET;
  logic [15:0] word_cap  = WORD_RESET;
  logic        toggle    = 1'b0;

  assign word_out        = word_cap;
  assign word_toggle_out = toggle;

  // ==========================================================================
  // Shift while selected
  // ==========================================================================
  // Oldest bits fall off the top, so extra edges keep the newest 16 bits
  always_ff @(posedge shift_clk_in) begin
    if (!select_load_strobe_n_in) begin
      shift_reg <= {shift_reg[14:0], serial_word_in};
    end
  end

  // ==========================================================================
  // Word capture on strobe rise
  // ==========================================================================
  // The strobe edge itself clocks the capture: the shift clock may be idle
  always_ff @(posedge select_load_strobe_n_in) begin
    word_cap <= shift_reg;
    toggle   <= ~toggle;
  end

endmodule : serial_word_shifter // serial_word_shifter

`default_nettype wire

//--- core/command_executor.sv
// Double-buffered code storage and sleep state driven by decoded commands
`timescale 1ns/100ps
`default_nettype none

module command_executor
  import dual_dac_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          word_valid_in,
  input  wire command_word_s word_in,
  output var  level_pair_s   input_regs_out,
  output var  level_pair_s   output_regs_out,
  output var  logic          sleep_out,
  output var  logic          bad_command_out
);

  logic load_a;
  logic load_b;
  logic update;
  logic wake;
  logic sleep;
  logic bad;

  // ==========================================================================
  // Decode
  // ==========================================================================
  always_comb begin
    load_a = 1'b0;
    load_b = 1'b0;
    update = 1'b0;
    wake   = 1'b0;
    sleep  = 1'b0;
    bad    = 1'b0;
    case (word_in.command_code)
      CMD_NOP:        ;
      CMD_LOAD_A:     load_a = 1'b1;
      CMD_LOAD_B:     load_b = 1'b1;
      CMD_UPDATE:     begin update = 1'b1; wake = 1'b1; end
      CMD_LOAD_A_UPD: begin load_a = 1'b1; update = 1'b1; wake = 1'b1; end
      CMD_LOAD_B_UPD: begin load_b = 1'b1; update = 1'b1; wake = 1'b1; end
      CMD_WAKE:       wake = 1'b1;
      CMD_SLEEP:      sleep = 1'b1;
      CMD_LOAD_BOTH:  begin
        load_a = 1'b1;
        load_b = 1'b1;
        update = 1'b1;
        wake   = 1'b1;
      end
      default:        bad = 1'b1;
    endcase
  end

  // ==========================================================================
  // Input registers
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      input_regs_out <= '{chan_a: LEVEL_RESET, chan_b: LEVEL_RESET};
    end else if (word_valid_in) begin
      if (load_a) begin
        input_regs_out.chan_a <= word_in.level_code;
      end
      if (load_b) begin
        input_regs_out.chan_b <= word_in.level_code;
      end
    end
  end

  // ==========================================================================
  // Output registers, always both at once, using freshly loaded codes
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      output_regs_out <= '{chan_a: LEVEL_RESET, chan_b: LEVEL_RESET};
    end else if (word_valid_in && update) begin
      output_regs_out.chan_a <= load_a ? word_in.level_code : input_regs_out.chan_a;
      output_regs_out.chan_b <= load_b ? word_in.level_code : input_regs_out.chan_b;
    end
  end

  // ==========================================================================
  // Sleep state and undefined-command flag
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sleep_out <= SLEEP_RESET;
    end else if (word_valid_in && sleep) begin
      sleep_out <= 1'b1;
    end else if (word_valid_in && wake) begin
      sleep_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bad_command_out <= 1'b0;
    end else if (word_valid_in) begin
      bad_command_out <= bad;
    end
  end

endmodule : command_executor // command_executor

`default_nettype wire

//--- core/dual_dac_serial_command_logic.sv
// Top of the dual converter serial command front end
// How it works
// - With strobe low, each rising shift clock edge shifts one data bit in.
// - Command code comes first, then level code, both most significant bit first.
// - The final two pad bits are shifted in but never used.
// - Strobe rising stops shifting and executes the held command.
// - Each channel has its own ten-bit input and output register.
// - Command 0000 changes nothing.
// - Commands 0001 and 0010 load input register A or B only.
// - Command 1000 copies both input registers to outputs and wakes.
// - Command 1001 loads A, copies both to outputs, and wakes.
// - Command 1010 loads B, copies both to outputs, and wakes.
// - Command 1101 only wakes; outputs resume held codes.
// - Command 1110 sleeps, keeps all registers, outputs go high impedance.
// - Command 1111 loads both inputs with one code, updates both, wakes.
// - Output registers always update together, never one channel alone.
// - Power-up clears both outputs to zero-scale.
// - Sleep ignores the level code and keeps stored settings.
`timescale 1ns/100ps
`default_nettype none

module dual_dac_serial_command_logic
  import dual_dac_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        shift_clk_in,
  input  wire logic        select_load_strobe_n_in,
  input  wire logic        serial_word_in,
  output var  logic [9:0]  input_code_a_out,
  output var  logic [9:0]  input_code_b_out,
  output var  logic [9:0]  output_code_a_out,
  output var  logic [9:0]  output_code_b_out,
  output var  logic        output_drive_en_out,
  output var  logic        sleep_out,
  output var  logic        word_done_out,
  output var  logic        bad_command_out
);

  logic [15:0]   link_word;
  logic          link_toggle;
  logic [2:0]    toggle_sync;
  logic [15:0]   word_hold;
  logic          word_valid;
  logic          exec_done;
  command_word_s decoded;
  level_pair_s   input_regs;
  level_pair_s   output_regs;
  logic          sleep_state;
  logic          bad_command;

  // ==========================================================================
  // Link domain
  // ==========================================================================
  serial_word_shifter u_shifter (
    .shift_clk_in            (shift_clk_in),
    .select_load_strobe_n_in (select_load_strobe_n_in),
    .serial_word_in          (serial_word_in),
    .word_out                (link_word),
    .word_toggle_out         (link_toggle)
  );

  // ==========================================================================
  // Crossing: toggle synchroniser, word is stable long before toggle arrives
  // ==========================================================================
  // Not reset: clearing it while the link toggle is high would fake a word on release
  always_ff @(posedge clk_in) begin
    toggle_sync <= {toggle_sync[1:0], link_toggle};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_valid <= 1'b0;
    end else begin
      word_valid <= toggle_sync[2] ^ toggle_sync[1];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_hold <= WORD_RESET;
    end else if (toggle_sync[2] ^ toggle_sync[1]) begin
      word_hold <= link_word;
    end
  end

  // Pad bits are dropped here
  assign decoded.command_code = word_hold[CMD_MSB:CMD_LSB];
  assign decoded.level_code   = word_hold[LEVEL_MSB:LEVEL_LSB];

  // ==========================================================================
  // Execution
  // ==========================================================================
  command_executor u_exec (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .word_valid_in   (word_valid),
    .word_in         (decoded),
    .input_regs_out  (input_regs),
    .output_regs_out (output_regs),
    .sleep_out       (sleep_state),
    .bad_command_out (bad_command)
  );

  // Done lines up with the output registers, set on the same edge as the executor's registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      exec_done <= 1'b0;
    end else begin
      exec_done <= word_valid;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      input_code_a_out    <= LEVEL_RESET;
      input_code_b_out    <= LEVEL_RESET;
      output_code_a_out   <= LEVEL_RESET;
      output_code_b_out   <= LEVEL_RESET;
      output_drive_en_out <= 1'b1;
      sleep_out           <= SLEEP_RESET;
      word_done_out       <= 1'b0;
      bad_command_out     <= 1'b0;
    end else begin
      input_code_a_out    <= input_regs.chan_a;
      input_code_b_out    <= input_regs.chan_b;
      output_code_a_out   <= output_regs.chan_a;
      output_code_b_out   <= output_regs.chan_b;
      output_drive_en_out <= ~sleep_state;
      sleep_out           <= sleep_state;
      word_done_out       <= exec_done;
      bad_command_out     <= bad_command;
    end
  end

endmodule : dual_dac_serial_command_logic // dual_dac_serial_command_logic

`default_nettype wire

//--- sim/dual_dac_monitor.sv
// Port checker for the dual converter command front end
`timescale 1ns/100ps
`default_nettype none

module dual_dac_monitor (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       shift_clk_in,
  input wire logic       select_load_strobe_n_in,
  input wire logic       serial_word_in,
  input wire logic [9:0] input_code_a_out,
  input wire logic [9:0] input_code_b_out,
  input wire logic [9:0] output_code_a_out,
  input wire logic [9:0] output_code_b_out,
  input wire logic       output_drive_en_out,
  input wire logic       sleep_out,
  input wire logic       word_done_out,
  input wire logic       bad_command_out
);
  // ==========
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence strobe_rise;
    $rose(select_load_strobe_n_in);
  endsequence
  sequence done_soon;
    ##[2:10] word_done_out;
  endsequence
  reset_clear_a: assert property ($fell(rst_in) |->
    output_code_a_out == 10'h000 && output_code_b_out == 10'h000 && input_code_a_out == 10'h000
    && input_code_b_out == 10'h000 && output_drive_en_out && !sleep_out) else $error("reset");
  word_exec_a: assert property (strobe_rise |-> done_soon) else $error("no exec");
  done_pulse_a: assert property (word_done_out |=> !word_done_out) else $error("done");
  done_cause_a: assert property (word_done_out |-> $past(select_load_strobe_n_in, 2))
    else $error("done cause");
  out_hold_a: assert property ($changed({output_code_a_out, output_code_b_out})
    |-> word_done_out) else $error("out change");
  in_hold_a: assert property ($changed({input_code_a_out, input_code_b_out})
    |-> word_done_out) else $error("in change");
  sleep_hold_a: assert property ($changed(sleep_out) |-> word_done_out)
    else $error("sleep change");
  drive_sleep_a: assert property (output_drive_en_out == !sleep_out)
    else $error("drive");
endmodule // dual_dac_monitor

bind dual_dac_serial_command_logic dual_dac_monitor monitor_inst (.clk_in, .rst_in,
  .shift_clk_in, .select_load_strobe_n_in, .serial_word_in, .input_code_a_out,
  .input_code_b_out, .output_code_a_out, .output_code_b_out, .output_drive_en_out,
  .sleep_out, .word_done_out, .bad_command_out);
`default_nettype wire

//--- sim/link_host.sv
// Host side of the three-wire link
`timescale 1ns/100ps
`default_nettype none

module link_host (
  output var logic shift_clk_out,
  output var logic strobe_n_out,
  output var logic data_out
);
  initial begin
    shift_clk_out = 1'b0;
    strobe_n_out  = 1'b1;
    data_out      = 1'b1;
  end
  // Sends the low nbits of w, first bit the highest
  task automatic send(input logic [17:0] w, input int nbits);
    shift_clk_out = 1'b0;
    strobe_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      data_out = w[i];
      #6 shift_clk_out = 1'b1;
      #6 shift_clk_out = 1'b0;
    end
    #6 strobe_n_out = 1'b1;
    data_out = ~data_out;
  endtask
endmodule // link_host
`default_nettype wire

//--- sim/test_dual_dac_serial_command_logic.sv
// Self-checking bench for the dual converter command front end
`timescale 1ns/100ps
`default_nettype none

module test_dual_dac_serial_command_logic;
  import dual_dac_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       sck, strobe_n, sdata;
  logic [9:0] in_a, in_b, out_a, out_b;
  logic       drive_en, sleep, done, bad;
  level_t     ea, eb, oa, ob;
  logic       es, eb_bad;
  int         error_cnt = 0;
  int         n_checks = 0;
  int         cycles = 0;

  always #2.5 clk_in = ~clk_in;

  link_host link_host_inst (.shift_clk_out(sck), .strobe_n_out(strobe_n), .data_out(sdata));
  dual_dac_serial_command_logic dual_dac_serial_command_logic_inst (.clk_in, .rst_in,
    .shift_clk_in(sck), .select_load_strobe_n_in(strobe_n), .serial_word_in(sdata),
    .input_code_a_out(in_a), .input_code_b_out(in_b), .output_code_a_out(out_a),
    .output_code_b_out(out_b), .output_drive_en_out(drive_en), .sleep_out(sleep),
    .word_done_out(done), .bad_command_out(bad));

  // ==========
  // Tasks
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_all();
    cmp(in_a, ea, "input a");
    cmp(in_b, eb, "input b");
    cmp(out_a, oa, "output a");
    cmp(out_b, ob, "output b");
    cmp(sleep, es, "sleep");
    cmp(drive_en, !es, "drive");
    cmp(bad, eb_bad, "bad");
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Extra leading bits are junk that the shifter must push out
  task automatic do_cmd(input logic [3:0] c, input level_t v, input logic [1:0] pad, input int extra);
    int w;
    link_host_inst.send({2'b10, c, v, pad}, 16 + extra);
    w = 0;
    while (done !== 1'b1 && w < 20) begin
      @(negedge clk_in);
      w++;
    end
    cmp(done, 1'b1, "done");
    if (c inside {CMD_LOAD_A, CMD_LOAD_A_UPD, CMD_LOAD_BOTH}) ea = v;
    if (c inside {CMD_LOAD_B, CMD_LOAD_B_UPD, CMD_LOAD_BOTH}) eb = v;
    if (c inside {CMD_UPDATE, CMD_LOAD_A_UPD, CMD_LOAD_B_UPD, CMD_LOAD_BOTH}) begin
      oa = ea;
      ob = eb;
    end
    if (c inside {CMD_UPDATE, CMD_LOAD_A_UPD, CMD_LOAD_B_UPD, CMD_LOAD_BOTH, CMD_WAKE}) es = 1'b0;
    if (c == CMD_SLEEP) es = 1'b1;
    eb_bad = !(c inside {CMD_NOP, CMD_LOAD_A, CMD_LOAD_B, CMD_UPDATE, CMD_LOAD_A_UPD,
      CMD_LOAD_B_UPD, CMD_WAKE, CMD_SLEEP, CMD_LOAD_BOTH});
    check_all();
    repeat (12) @(negedge clk_in);
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end

  // ==========
  // Sequence
  initial begin
    {ea, eb, oa, ob, es, eb_bad} = '0;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check_all();
    do_cmd(CMD_LOAD_A, 10'h3ff, 2'b11, 0);
    do_cmd(CMD_LOAD_B, 10'h155, 2'b00, 0);
    do_cmd(CMD_NOP, 10'h0aa, 2'b01, 0);
    do_cmd(CMD_SLEEP, 10'h123, 2'b10, 0);
    do_cmd(CMD_LOAD_A, 10'h2aa, 2'b11, 2);
    do_cmd(CMD_UPDATE, 10'h001, 2'b00, 0);
    do_cmd(CMD_LOAD_A_UPD, 10'h200, 2'b01, 0);
    do_cmd(CMD_LOAD_B_UPD, 10'h001, 2'b10, 0);
    do_cmd(CMD_SLEEP, 10'h3ff, 2'b00, 0);
    do_cmd(4'h5, 10'h0f0, 2'b00, 0);
    do_cmd(CMD_LOAD_B, 10'h0f0, 2'b01, 0);
    do_cmd(CMD_WAKE, 10'h0f0, 2'b11, 0);
    do_cmd(CMD_LOAD_BOTH, 10'h2cd, 2'b01, 0);
    stop_test();
  end
endmodule // test_dual_dac_serial_command_logic
`default_nettype wire
